// [hw/exm_monitor.sv]
// Purpose: local and global exclusive access monitor for N requesters
// Assumes: requester supplies address, attribute and unique id each cycle
// Notes:   status valid one cycle after the request
`timescale 1ns/10ps
module exm_monitor #(
    parameter int N    = exm_pkg::EXM_NUM_REQ,
    parameter int IW   = exm_pkg::EXM_ID_W,
    parameter int GRAN = exm_pkg::EXM_GRAN_BYTES
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire exm_pkg::exm_req_t req,
    input  wire logic              xlate_en,
    input  wire logic              tlb_shared,
    output logic                   stat_valid,
    output logic                   stat_fail,
    output logic                   mem_wr_en,
    output logic [exm_pkg::EXM_ADDR_W-1:0] mem_wr_addr
);
    import exm_pkg::*;

    if (GRAN < EXM_EXCL_SIZE || GRAN > EXM_MAX_GRAN || (GRAN & (GRAN - 1)) != 0 ||
        N > (1 << IW) || N < 1) begin : g_bad_param
        $error("exm_monitor: bad parameters");
    end

    localparam int GB = $clog2(GRAN);

    // ----------------------------------------------------------------
    // Address and attribute selection
    // ----------------------------------------------------------------
    logic [EXM_ADDR_W-1:0] tag_addr;
    logic                  is_shared;
    assign tag_addr  = xlate_en ? req.paddr : req.vaddr;
    assign is_shared = xlate_en ? tlb_shared : req.shared;

    // ----------------------------------------------------------------
    // Records, one local and one global per requester
    // ----------------------------------------------------------------
    exm_rec_t loc_q [N];
    exm_rec_t glb_q [N];
    logic     loc_hit, glb_hit, pass;

    // Local check: a 4-byte mark at a word-aligned address
    assign loc_hit = (loc_q[req.id].state == EXM_EXCLUSIVE) &&
                     (loc_q[req.id].addr[EXM_ADDR_W-1:2] == tag_addr[EXM_ADDR_W-1:2]);
    // Global records serve all shared memory, so no shared outcome is left open
    assign glb_hit = (glb_q[req.id].state == EXM_EXCLUSIVE) &&
                     (glb_q[req.id].addr[EXM_ADDR_W-1:GB] == tag_addr[EXM_ADDR_W-1:GB]);
    // Pre-update values are used, so same-cycle clears cannot race the decision
    assign pass = loc_hit && (!is_shared || glb_hit);

    logic do_stex, do_ldex, clr_addr;
    assign do_stex  = req.op == EXM_OP_STEX;
    assign do_ldex  = req.op == EXM_OP_LDEX;
    assign clr_addr = is_shared &&
                      ((req.op == EXM_OP_STORE) || (do_stex && pass));

    logic [EXM_ADDR_W-1:0] last_byte;
    assign last_byte = tag_addr + EXM_ADDR_W'(req.size) - EXM_ADDR_W'(1);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_req
            logic overlap;
            // Granule overlap: first or last byte in the marked granule
            assign overlap = (glb_q[g].addr[EXM_ADDR_W-1:GB] == tag_addr[EXM_ADDR_W-1:GB]) ||
                             (glb_q[g].addr[EXM_ADDR_W-1:GB] == last_byte[EXM_ADDR_W-1:GB]);

            always_ff @(posedge mclk) begin
                if (rst) begin
                    loc_q[g] <= '0;
                end else if (ce && req.op != EXM_OP_NONE && req.id == IW'(g)) begin
                    if (do_ldex) begin
                        loc_q[g].state <= EXM_EXCLUSIVE;
                        loc_q[g].addr  <= {tag_addr[EXM_ADDR_W-1:2], 2'h0};
                    end else if (do_stex) begin
                        loc_q[g].state <= EXM_OPEN;
                    end
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    glb_q[g] <= '0;
                end else if (ce) begin
                    if (do_ldex && is_shared && req.id == IW'(g)) begin
                        glb_q[g].state <= EXM_EXCLUSIVE;
                        glb_q[g].addr  <= {tag_addr[EXM_ADDR_W-1:GB], GB'(0)};
                    end else if (clr_addr && req.id != IW'(g) && overlap) begin
                        glb_q[g].state <= EXM_OPEN;
                    end
                end
            end

            a_reset_open: assert property (@(posedge mclk)
                rst |=> loc_q[g].state == EXM_OPEN && glb_q[g].state == EXM_OPEN)
                else $error("reset left record marked");
            a_clear_glb: assert property (@(posedge mclk) disable iff (rst)
                ce && clr_addr && req.id != IW'(g) && overlap |=> glb_q[g].state == EXM_OPEN)
                else $error("overlapping global mark survived a clear");
            a_glb_align: assert property (@(posedge mclk) disable iff (rst)
                glb_q[g].state == EXM_EXCLUSIVE |-> glb_q[g].addr[GB-1:0] == '0)
                else $error("global mark not granule aligned");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Registered copy of the local records
    // ----------------------------------------------------------------
    // Flops serve the local hit compare; bank copy is only checked against them by a_shadow_match
    exm_rec_t loc_wr_rec;
    exm_rec_t loc_shadow;
    logic     loc_wr;
    assign loc_wr = do_ldex || do_stex;

    always_comb begin
        loc_wr_rec = loc_q[req.id];
        if (do_ldex) begin
            loc_wr_rec.state = EXM_EXCLUSIVE;
            loc_wr_rec.addr  = {tag_addr[EXM_ADDR_W-1:2], 2'h0};
        end else begin
            loc_wr_rec.state = EXM_OPEN;
        end
    end

    exm_rec_bank #(
        .N  (N),
        .IW (IW)
    ) u_loc_bank (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .wr_en   (loc_wr),
        .wr_idx  (req.id),
        .wr_data (loc_wr_rec),
        .rd_idx  (req.id),
        .rd_data (loc_shadow)
    );

    a_shadow_match: assert property (@(posedge mclk) disable iff (rst)
        $past(ce) && !$past(rst) |-> loc_shadow == $past(loc_q[req.id]))
        else $error("local record copy disagrees");

    // ----------------------------------------------------------------
    // Status and memory write
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_valid  <= 1'b0;
            stat_fail   <= EXM_STAT_FAIL;
            mem_wr_en   <= 1'b0;
            mem_wr_addr <= '0;
        end else if (ce) begin
            stat_valid  <= do_stex;
            stat_fail   <= do_stex ? (pass ? EXM_STAT_OK : EXM_STAT_FAIL) : stat_fail;
            mem_wr_en   <= (do_stex && pass) || (req.op == EXM_OP_STORE);
            mem_wr_addr <= tag_addr;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_stex_status: assert property (@(posedge mclk) disable iff (rst)
        ce && do_stex |=> stat_valid && (stat_fail == !$past(pass)))
        else $error("store-exclusive status wrong");
    a_ldex_local: assert property (@(posedge mclk) disable iff (rst)
        ce && do_ldex |=> loc_q[$past(req.id)].state == EXM_EXCLUSIVE)
        else $error("local mark not set");
    a_stex_open: assert property (@(posedge mclk) disable iff (rst)
        ce && do_stex |=> loc_q[$past(req.id)].state == EXM_OPEN)
        else $error("local record not cleared");
    a_open_fail: assert property (@(posedge mclk) disable iff (rst)
        ce && do_stex && loc_q[req.id].state == EXM_OPEN |=> stat_fail)
        else $error("open record passed");
    a_glb_gate: assert property (@(posedge mclk) disable iff (rst)
        ce && do_stex && is_shared && glb_q[req.id].state == EXM_OPEN |=> stat_fail)
        else $error("shared store passed without global mark");
    a_wr_follow: assert property (@(posedge mclk) disable iff (rst)
        ce && do_stex |=> mem_wr_en == !stat_fail)
        else $error("write and status disagree");
    a_ldex_glb: assert property (@(posedge mclk) disable iff (rst)
        ce && do_ldex && is_shared |=> glb_q[$past(req.id)].state == EXM_EXCLUSIVE)
        else $error("global mark not set");
    a_valid_pulse: assert property (@(posedge mclk) disable iff (rst)
        ce && !do_stex |=> !stat_valid)
        else $error("status valid without store-exclusive");
    a_fail_hold: assert property (@(posedge mclk) disable iff (rst)
        !ce || !do_stex |=> $stable(stat_fail))
        else $error("status changed without store-exclusive");
    a_store_write: assert property (@(posedge mclk) disable iff (rst)
        ce && req.op == EXM_OP_STORE |=> mem_wr_en)
        else $error("ordinary store not passed to memory");
    a_tag_xlate: assert property (@(posedge mclk) disable iff (rst)
        ce && xlate_en |=> mem_wr_addr == $past(req.paddr))
        else $error("translated address not used");
    a_tag_raw: assert property (@(posedge mclk) disable iff (rst)
        ce && !xlate_en |=> mem_wr_addr == $past(req.vaddr))
        else $error("untranslated address not used");
    c_stex_ok: cover property (@(posedge mclk) stat_valid && !stat_fail);
    c_stex_bad: cover property (@(posedge mclk) stat_valid && stat_fail);
    c_clear_other: cover property (@(posedge mclk) ce && clr_addr && req.op == EXM_OP_STORE);
    c_shared_pass: cover property (@(posedge mclk) ce && do_stex && is_shared && pass);
endmodule

// [hw/exm_rec_bank.sv]
// Purpose: per-requester record storage, registered read port
// Assumes: one write port, one read port
// Notes:   reset opens every record
`timescale 1ns/10ps
module exm_rec_bank #(
    parameter int N  = exm_pkg::EXM_NUM_REQ,
    parameter int IW = exm_pkg::EXM_ID_W
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              wr_en,
    input  wire logic [IW-1:0]     wr_idx,
    input  wire exm_pkg::exm_rec_t wr_data,
    input  wire logic [IW-1:0]     rd_idx,
    output exm_pkg::exm_rec_t      rd_data
);
    import exm_pkg::*;

    if (N < 1 || N > (1 << IW)) begin : g_bad_param
        $error("exm_rec_bank: bad parameters");
    end

    exm_rec_t mem_q [N];
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                mem_q[i] <= '0;
            end
            rd_data <= '0;
        end else if (ce) begin
            if (wr_en) begin
                mem_q[wr_idx] <= wr_data;
            end
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule

// [include/exm_pkg.sv]
// Purpose: shared constants and types for the exclusive access monitor
// Assumes: one request per cycle from a single memory port
// Notes:   region granule is a power of two up to 128 bytes
package exm_pkg;
    localparam int EXM_ADDR_W      = 32;
    localparam int EXM_NUM_REQ     = 4;
    localparam int EXM_ID_W        = 2;
    localparam int EXM_GRAN_BYTES  = 8;
    localparam int EXM_MAX_GRAN    = 128;
    localparam int EXM_EXCL_SIZE   = 4;
    localparam logic EXM_STAT_OK   = 1'b0;
    localparam logic EXM_STAT_FAIL = 1'b1;

    typedef enum logic [1:0] {
        EXM_OP_NONE  = 2'h0,
        EXM_OP_LDEX  = 2'h1,
        EXM_OP_STEX  = 2'h3,
        EXM_OP_STORE = 2'h2
    } exm_op_t;

    typedef enum logic {
        EXM_OPEN      = 1'b0,
        EXM_EXCLUSIVE = 1'b1
    } exm_state_t;

    typedef struct packed {
        exm_op_t                 op;
        logic [EXM_ID_W-1:0]     id;
        logic [EXM_ADDR_W-1:0]   vaddr;
        logic [EXM_ADDR_W-1:0]   paddr;
        logic                    shared;
        logic [7:0]              size;
    } exm_req_t;

    typedef struct packed {
        exm_state_t              state;
        logic [EXM_ADDR_W-1:0]   addr;
    } exm_rec_t;
endpackage

// [test/exm_mem_sink.sv]
// Purpose: memory side model taking writes from the monitor
// Assumes: mem_wr_en is a one-cycle pulse
// Notes:   keeps a write count and the last write address
`timescale 1ns/10ps
module exm_mem_sink (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          mem_wr_en,
    input  wire logic [exm_pkg::EXM_ADDR_W-1:0] mem_wr_addr,
    output logic [7:0]                         wr_count_q,
    output logic [exm_pkg::EXM_ADDR_W-1:0]     last_addr_q
);
    import exm_pkg::*;
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_count_q  <= 8'h00;
            last_addr_q <= '0;
        end else if (mem_wr_en) begin
            wr_count_q  <= wr_count_q + 8'h01;
            last_addr_q <= mem_wr_addr;
        end
    end
endmodule

// [test/tb_top.sv]
// Purpose: self-checking bench for the exclusive access monitor
// Assumes: answer one cycle after a request, inputs set at falling edge
// Notes:   physical address is the virtual one plus a fixed offset
`timescale 1ns/10ps
module tb_top;
    import exm_pkg::*;
    logic                  mclk = 1'b0;
    logic                  rst = 1'b1;
    logic                  ce = 1'b1;
    logic                  xlate_en = 1'b0;
    logic                  tlb_shared = 1'b0;
    exm_req_t              req = '0;
    logic                  stat_valid, stat_fail, mem_wr_en;
    logic [EXM_ADDR_W-1:0] mem_wr_addr, last_addr;
    logic [7:0]            wr_count;
    int                    fails = 0;
    int                    n_tests = 0;
    always #25 mclk = ~mclk;
    exm_monitor dut (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .xlate_en(xlate_en),
        .tlb_shared(tlb_shared), .stat_valid(stat_valid), .stat_fail(stat_fail),
        .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr));
    exm_mem_sink sink (.mclk(mclk), .rst(rst), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .wr_count_q(wr_count), .last_addr_q(last_addr));
    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, held a full cycle; answer seen at the next falling edge
    task automatic issue(input exm_op_t op, input logic [EXM_ID_W-1:0] id,
                         input logic [31:0] va, input logic sh);
        @(negedge mclk);
        req.op = op;
        req.id = id;
        req.vaddr = va;
        req.paddr = va + 32'h4000_0000;
        req.shared = sh;
        req.size = 8'h04;
        @(negedge mclk);
        req.op = EXM_OP_NONE;
    endtask
    task automatic stex(input logic [EXM_ID_W-1:0] id, input logic [31:0] a,
                        input logic sh, input logic f);
        issue(EXM_OP_STEX, id, a, sh);
        chk(stat_valid, 1'b1);
        chk(stat_fail, f);
        chk(mem_wr_en, !f);
    endtask
    task automatic sc_reset();
        chk({stat_valid, stat_fail, mem_wr_en}, 3'b010);
        stex(2'h0, 32'h1000, 1'b0, 1'b1);
    endtask
    task automatic sc_local();
        issue(EXM_OP_LDEX, 2'h0, 32'h1000, 1'b0);
        chk(mem_wr_addr, 32'h1000);
        stex(2'h0, 32'h1000, 1'b0, 1'b0);
        @(negedge mclk);
        chk(last_addr, 32'h1000);
        chk(wr_count, 32'h1);
        stex(2'h0, 32'h1000, 1'b0, 1'b1);
    endtask
    // Context switch: dummy store-exclusive to a spare word opens the record
    task automatic sc_ctx();
        issue(EXM_OP_LDEX, 2'h0, 32'h1000, 1'b0);
        stex(2'h0, 32'h2000, 1'b0, 1'b1);
        stex(2'h0, 32'h1000, 1'b0, 1'b1);
    endtask
    task automatic sc_clear(input logic [31:0] st, input logic f1);
        issue(EXM_OP_LDEX, 2'h1, 32'h3000, 1'b1);
        issue(EXM_OP_LDEX, 2'h2, 32'h3000, 1'b1);
        issue(EXM_OP_STORE, 2'h3, st, 1'b1);
        stex(2'h1, 32'h3000, 1'b1, f1);
        stex(2'h2, 32'h3000, 1'b1, 1'b1);
    endtask
    // Shared attribute and tag address come from translation when enabled
    task automatic sc_xlate();
        xlate_en = 1'b1;
        tlb_shared = 1'b1;
        issue(EXM_OP_LDEX, 2'h3, 32'h5000, 1'b0);
        chk(mem_wr_addr, 32'h4000_5000);
        issue(EXM_OP_STORE, 2'h0, 32'h5004, 1'b0);
        stex(2'h3, 32'h5000, 1'b0, 1'b1);
        issue(EXM_OP_LDEX, 2'h3, 32'h5000, 1'b0);
        stex(2'h3, 32'h5000, 1'b0, 1'b0);
        chk(mem_wr_addr, 32'h4000_5000);
        xlate_en = 1'b0;
        tlb_shared = 1'b0;
    endtask
    // Clock enable low: requests ignored, outputs hold
    task automatic sc_freeze();
        ce = 1'b0;
        issue(EXM_OP_LDEX, 2'h0, 32'h6000, 1'b0);
        chk(mem_wr_addr, 32'h4000_5000);
        ce = 1'b1;
        stex(2'h0, 32'h6000, 1'b0, 1'b1);
    endtask
    // Mid-run reset drops marks taken just before it
    task automatic sc_rerun();
        issue(EXM_OP_LDEX, 2'h1, 32'h7000, 1'b1);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        chk({stat_valid, stat_fail, mem_wr_en}, 3'b010);
        chk(mem_wr_addr, 32'h0);
        stex(2'h1, 32'h7000, 1'b1, 1'b1);
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        sc_reset();
        sc_local();
        sc_ctx();
        sc_clear(32'h3004, 1'b1);
        sc_clear(32'h3008, 1'b0);
        sc_clear(32'h2ffe, 1'b1);
        sc_xlate();
        sc_freeze();
        sc_rerun();
        complete_run();
    end
    // Guard against a hung run
    initial begin
        #200000;
        fails++;
        complete_run();
    end
endmodule
